// [common/toa_pkg.sv]
// Constants, register map and types of the transmit overhead and alarm block
// Overview of operation
// - Ft pattern overwrites F-bits in SF, loop carrier, T1DM
// - SF inserts Fs pattern when multiframe insert set
// - Multiframe insert gives FPS in ESF, FAS/NFAS in E1
// - Framing generator can insert MFAS pattern too
// - AIS is unframed all ones over everything
// - Manual AIS bit overwrites transmitted data with AIS
// - Alternate clock option times manual and clock-loss AIS from alternate clock
// - Transmit clock returning ends clock-loss AIS and clears loss
// - AIS sent on receive signal loss when enabled
// - Yellow forces bit 2 of every slot low in SF, ESF and loop carrier, except Japanese SF
// - Japanese yellow sets F-bit 12 to one
// - T1DM yellow clears Y bit of sync byte
// - E1 remote alarm sets A bit of slot zero
// - Yellow inserted only with insert enable, else PCM
// - Manual yellow overwrites yellow positions at once
// - Automatic yellow follows receive loss of frame
// - Integration delays loss indication and yellow 2.5 s
// - Integrated yellow lasts one second after loss clears
package toa_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int TOA_CLK_MHZ       = 125;
    localparam int TOA_LOF_INTEG_MS  = 2500;
    localparam int TOA_YEL_HOLD_MS   = 1000;
    localparam int TOA_CYC_PER_MS    = TOA_CLK_MHZ * 1000;
    localparam int TOA_LOF_INTEG_CYC = TOA_LOF_INTEG_MS * TOA_CYC_PER_MS;
    localparam int TOA_YEL_HOLD_CYC  = TOA_YEL_HOLD_MS * TOA_CYC_PER_MS;
    localparam int TOA_TMR_W         = 29;
    localparam logic [3:0] TOA_LOC_EDGES = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // Register indices (byte address is four times the index)
    localparam logic [7:0] TOA_IDX_LOOP = 8'h14;
    localparam logic [7:0] TOA_IDX_RECEIVE_ALARM_CONFIG = 8'h45;
    localparam logic [7:0] TOA_IDX_ALARM_STATUS_ONE = 8'h47;
    localparam logic [7:0] TOA_IDX_TXST = 8'h48;
    localparam logic [7:0] TOA_IDX_TLIU = 8'h68;
    localparam logic [7:0] TOA_IDX_TX_FRAME_FORMAT = 8'h72;
    localparam logic [7:0] TOA_IDX_TX_ALARM_CONFIG = 8'h75;

    // Field positions
    localparam int TOA_LOOP_LINE    = 0;
    localparam int TOA_RECEIVE_ALARM_CONFIG_INTEG   = 0;
    localparam int TOA_ALARM_STATUS_ONE_LOS     = 0;
    localparam int TOA_ALARM_STATUS_ONE_LOF     = 1;
    localparam int TOA_TXST_LOC     = 0;
    localparam int TOA_TLIU_ALTCLK  = 0;
    localparam int TOA_TX_FRAME_FORMAT_FMT_LO  = 0;
    localparam int TOA_TX_FRAME_FORMAT_FMT_HI  = 2;
    localparam int TOA_TX_FRAME_FORMAT_FBIT    = 3;
    localparam int TOA_TX_FRAME_FORMAT_MF      = 4;
    localparam int TOA_TX_FRAME_FORMAT_YEL     = 5;
    localparam int TOA_TX_FRAME_FORMAT_JAPANESE_REMOTE_ALARM    = 6;
    localparam int TOA_TX_ALARM_CONFIG_AIS     = 0;
    localparam int TOA_TX_ALARM_CONFIG_AUTOAIS = 1;
    localparam int TOA_TX_ALARM_CONFIG_YEL     = 2;
    localparam int TOA_TX_ALARM_CONFIG_AUTOYEL = 3;
    localparam logic [7:0] TOA_REG_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Frame formats and frame geometry
    typedef enum logic [2:0] {
        TOA_FMT_SF   = 3'h0,
        TOA_FMT_ESF  = 3'h1,
        TOA_FMT_LCF  = 3'h2,
        TOA_FMT_T1DM = 3'h3,
        TOA_FMT_E1   = 3'h4
    } toa_fmt_t;

    localparam logic [7:0] TOA_BIT_LAST_T1 = 8'hc0;
    localparam logic [7:0] TOA_BIT_LAST_E1 = 8'hff;
    localparam logic [4:0] TOA_MF_LAST_SF  = 5'h0b;
    localparam logic [4:0] TOA_MF_LAST_ESF = 5'h17;
    localparam logic [4:0] TOA_MF_LAST_E1  = 5'h0f;
    localparam logic [4:0] TOA_MFAS_FRAMES = 5'h0c;
    localparam logic [5:0] TOA_FS_PAT      = 6'h1c;
    localparam logic [5:0] TOA_FPS_PAT     = 6'h34;
    localparam logic [5:0] TOA_MFAS_PAT    = 6'h34;
    localparam logic [7:0] TOA_FAS_BYTE    = 8'h1b;
    localparam logic [2:0] TOA_BIT2_POS    = 3'h1;
    localparam logic [4:0] TOA_SYNC_SLOT   = 5'h17;
    localparam logic [2:0] TOA_Y_POS       = 3'h5;
    localparam logic [2:0] TOA_A_POS       = 3'h2;
    localparam logic [2:0] TOA_NFAS_POS    = 3'h1;

    // Pin slots in the synchroniser bank
    localparam int TOA_NPINS    = 5;
    localparam int TOA_PIN_TXCK = 0;
    localparam int TOA_PIN_AE1  = 1;
    localparam int TOA_PIN_AT1  = 2;
    localparam int TOA_PIN_PCM  = 3;
    localparam int TOA_PIN_FSYN = 4;

endpackage : toa_pkg

// [src/toa_tx_overhead.sv]
// Transmit overhead, AIS and yellow alarm insertion for one framer
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module toa_tx_overhead
    import toa_pkg::*;
#(
    parameter int LOF_INTEG_CYC = TOA_LOF_INTEG_CYC,
    parameter int YEL_HOLD_CYC  = TOA_YEL_HOLD_CYC
) (
    // System
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Register port
    input  wire logic [9:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Link pins
    input  wire logic       tx_clock_in,
    input  wire logic       alt_e1_clock_in,
    input  wire logic       alt_t1_clock_in,
    input  wire logic       system_pcm_in,
    input  wire logic       tx_frame_sync_in,
    // Receiver status
    input  wire logic       rx_signal_lost,
    input  wire logic       rx_frame_lost,
    // Line side
    output logic            tx_line_data,
    output logic            tx_line_bit_stb,
    // Status
    output logic            tx_clock_lost,
    output logic            ais_active,
    output logic            remote_alarm_active,
    output logic            line_loopback_en
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, change taken when stages 2, 3 agree
    logic [TOA_NPINS-1:0] s1_ff;
    logic [TOA_NPINS-1:0] s2_ff;
    logic [TOA_NPINS-1:0] s3_ff;
    logic [TOA_NPINS-1:0] filt_ff;
    wire  [TOA_NPINS-1:0] pins_in;
    wire  [TOA_NPINS-1:0] agree;
    wire  [TOA_NPINS-1:0] rise;
    assign pins_in = {tx_frame_sync_in, system_pcm_in, alt_t1_clock_in,
                      alt_e1_clock_in, tx_clock_in};
    assign agree   = ~(s2_ff ^ s3_ff);
    assign rise    = agree & s3_ff & ~filt_ff;
    genvar gi;
    generate
        for (gi = 0; gi < TOA_NPINS; gi++) begin : g_sync
            // One synchroniser per pin
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    s1_ff[gi]   <= 1'b0;
                    s2_ff[gi]   <= 1'b0;
                    s3_ff[gi]   <= 1'b0;
                    filt_ff[gi] <= 1'b0;
                end else begin
                    s1_ff[gi]   <= pins_in[gi];
                    s2_ff[gi]   <= s1_ff[gi];
                    s3_ff[gi]   <= s2_ff[gi];
                    filt_ff[gi] <= agree[gi] ? s3_ff[gi] : filt_ff[gi];
                end
            end
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////////
    // Register port
    logic [7:0] loop_ff;
    logic [7:0] receive_alarm_config_ff;
    logic [7:0] tliu_ff;
    logic [7:0] tx_frame_format_ff;
    logic [7:0] tx_alarm_config_ff;
    logic [7:0] reg_rdata_ff;
    logic [7:0] nxt_rdata;
    logic       tx_clock_lost_ff;
    logic       lof_ind_ff;
    // Address decode: aligned words only
    wire       aligned = (reg_addr[1:0] == 2'h0);
    wire [7:0] reg_idx = reg_addr[9:2];
    wire       wr_ok   = reg_wr & aligned;
    wire       rd_ok   = reg_rd & aligned;
    // Writable registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            loop_ff <= TOA_REG_RST;
            receive_alarm_config_ff <= TOA_REG_RST;
            tliu_ff <= TOA_REG_RST;
            tx_frame_format_ff <= TOA_REG_RST;
            tx_alarm_config_ff <= TOA_REG_RST;
        end else if (wr_ok) begin
            case (reg_idx)
                TOA_IDX_LOOP: loop_ff <= reg_wdata;
                TOA_IDX_RECEIVE_ALARM_CONFIG: receive_alarm_config_ff <= reg_wdata;
                TOA_IDX_TLIU: tliu_ff <= reg_wdata;
                TOA_IDX_TX_FRAME_FORMAT: tx_frame_format_ff <= reg_wdata;
                TOA_IDX_TX_ALARM_CONFIG: tx_alarm_config_ff <= reg_wdata;
                default: ;
            endcase
        end
    end
    // Read selection; unmapped reads return zero
    always_comb begin
        nxt_rdata = 8'h00;
        case (reg_idx)
            TOA_IDX_LOOP: nxt_rdata = loop_ff;
            TOA_IDX_RECEIVE_ALARM_CONFIG: nxt_rdata = receive_alarm_config_ff;
            TOA_IDX_TLIU: nxt_rdata = tliu_ff;
            TOA_IDX_TX_FRAME_FORMAT: nxt_rdata = tx_frame_format_ff;
            TOA_IDX_TX_ALARM_CONFIG: nxt_rdata = tx_alarm_config_ff;
            TOA_IDX_ALARM_STATUS_ONE: begin
                nxt_rdata[TOA_ALARM_STATUS_ONE_LOS] = rx_signal_lost;
                nxt_rdata[TOA_ALARM_STATUS_ONE_LOF] = lof_ind_ff;
            end
            TOA_IDX_TXST: nxt_rdata[TOA_TXST_LOC] = tx_clock_lost_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end
    // Read data stands for the one cycle after the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata_ff <= 8'h00;
        end else begin
            reg_rdata_ff <= rd_ok ? nxt_rdata : 8'h00;
        end
    end
    // Control fields
    wire      integ_en   = receive_alarm_config_ff[TOA_RECEIVE_ALARM_CONFIG_INTEG];
    wire      alt_ck_en  = tliu_ff[TOA_TLIU_ALTCLK];
    wire      insert_frame_bit_en   = tx_frame_format_ff[TOA_TX_FRAME_FORMAT_FBIT];
    wire      insert_multiframe_en     = tx_frame_format_ff[TOA_TX_FRAME_FORMAT_MF];
    wire      insert_remote_alarm_en    = tx_frame_format_ff[TOA_TX_FRAME_FORMAT_YEL];
    wire      japanese_remote_alarm       = tx_frame_format_ff[TOA_TX_FRAME_FORMAT_JAPANESE_REMOTE_ALARM];
    wire      man_ais    = tx_alarm_config_ff[TOA_TX_ALARM_CONFIG_AIS];
    wire      ais_on_signal_loss_en   = tx_alarm_config_ff[TOA_TX_ALARM_CONFIG_AUTOAIS];
    wire      man_yel    = tx_alarm_config_ff[TOA_TX_ALARM_CONFIG_YEL];
    wire      remote_alarm_on_lof_en   = tx_alarm_config_ff[TOA_TX_ALARM_CONFIG_AUTOYEL];
    wire [2:0] fmt       = tx_frame_format_ff[TOA_TX_FRAME_FORMAT_FMT_HI:TOA_TX_FRAME_FORMAT_FMT_LO];
    wire      is_e1      = (fmt == TOA_FMT_E1);
    wire      is_t1      = ~is_e1;
    ////////////////////////////////////////////////////////////////////////
    // Transmit clock loss watch, counted on alternate clock edges
    logic [3:0] loc_cnt_ff;
    wire        tx_edge  = rise[TOA_PIN_TXCK];
    wire        alt_edge = is_e1 ? rise[TOA_PIN_AE1] : rise[TOA_PIN_AT1];
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            loc_cnt_ff       <= 4'h0;
            tx_clock_lost_ff <= 1'b0;
        end else if (tx_edge || !alt_ck_en) begin
            loc_cnt_ff       <= 4'h0;
            tx_clock_lost_ff <= 1'b0;
        end else if (alt_edge && !tx_clock_lost_ff) begin
            loc_cnt_ff <= loc_cnt_ff + 4'h1;
            if (loc_cnt_ff == TOA_LOC_EDGES - 4'h1) begin
                tx_clock_lost_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame position, realigned by the multiframe sync pin
    logic [7:0] bit_ff;
    logic [4:0] frm_ff;
    logic       fs_pend_ff;
    logic [7:0] nxt_bit;
    logic [4:0] nxt_frm;
    wire        resync   = fs_pend_ff | rise[TOA_PIN_FSYN];
    wire  [7:0] bit_last = is_e1 ? TOA_BIT_LAST_E1 : TOA_BIT_LAST_T1;
    wire  [4:0] mf_last  = is_e1 ? TOA_MF_LAST_E1 :
                           (fmt == TOA_FMT_ESF) ? TOA_MF_LAST_ESF :
                           TOA_MF_LAST_SF;
    // Position of the bit taken at this transmit clock edge
    always_comb begin
        nxt_bit = bit_ff + 8'h01;
        nxt_frm = frm_ff;
        if (resync) begin
            nxt_bit = 8'h00;
            nxt_frm = 5'h00;
        end else if (bit_ff == bit_last) begin
            nxt_bit = 8'h00;
            nxt_frm = (frm_ff == mf_last) ? 5'h00 : frm_ff + 5'h01;
        end
    end
    // Sync pending flag: a new sync edge wins over consumption
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bit_ff     <= TOA_BIT_LAST_T1;
            frm_ff     <= TOA_MF_LAST_SF;
            fs_pend_ff <= 1'b0;
        end else begin
            if (tx_edge) begin
                bit_ff <= nxt_bit;
                frm_ff <= nxt_frm;
            end
            fs_pend_ff <= rise[TOA_PIN_FSYN] | (fs_pend_ff & ~tx_edge);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Yellow alarm source with loss-of-frame integration and hold
    logic [TOA_TMR_W-1:0] lof_cnt_ff;
    logic [TOA_TMR_W-1:0] hold_cnt_ff;
    wire                  hold_act = (hold_cnt_ff != '0);
    wire                  auto_src = remote_alarm_on_lof_en & (lof_ind_ff | hold_act);
    wire                  yel_src  = man_yel | auto_src;
    wire                  yel_ins  = insert_remote_alarm_en & yel_src;
    // Indication follows the input, or waits for a continuous loss
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lof_cnt_ff <= '0;
            lof_ind_ff <= 1'b0;
        end else if (!integ_en) begin
            lof_cnt_ff <= '0;
            lof_ind_ff <= rx_frame_lost;
        end else if (!rx_frame_lost) begin
            lof_cnt_ff <= '0;
            lof_ind_ff <= 1'b0;
        end else if (lof_cnt_ff == TOA_TMR_W'(LOF_INTEG_CYC - 1)) begin
            lof_ind_ff <= 1'b1;
        end else begin
            lof_cnt_ff <= lof_cnt_ff + 1'b1;
        end
    end
    // Hold timer reloads while loss stands, runs down after it clears
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hold_cnt_ff <= '0;
        end else if (integ_en && lof_ind_ff) begin
            hold_cnt_ff <= TOA_TMR_W'(YEL_HOLD_CYC);
        end else if (!integ_en) begin
            hold_cnt_ff <= '0;
        end else if (hold_act) begin
            hold_cnt_ff <= hold_cnt_ff - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Overhead insertion on the bit at the current position
    logic       ovh_bit;
    wire        pcm      = filt_ff[TOA_PIN_PCM];
    wire        fbit     = is_t1 & (nxt_bit == 8'h00);
    wire  [7:0] t1b      = nxt_bit - 8'h01;
    wire  [4:0] slot     = is_e1 ? nxt_bit[7:3] : t1b[7:3];
    wire  [2:0] pos      = is_e1 ? nxt_bit[2:0] : t1b[2:0];
    wire        ft_frm   = ~nxt_frm[0];
    wire  [2:0] k2       = nxt_frm[3:1];
    wire  [2:0] k4       = nxt_frm[4:2];
    wire        jy_mode  = japanese_remote_alarm & (fmt == TOA_FMT_SF);
    wire        yb2_mode = ~jy_mode & ((fmt == TOA_FMT_SF) |
                           (fmt == TOA_FMT_ESF) | (fmt == TOA_FMT_LCF));
    // PCM passes unless a pattern owns the position
    always_comb begin
        ovh_bit = pcm;
        if (fbit) begin
            if (insert_frame_bit_en && ft_frm && fmt != TOA_FMT_ESF) begin
                ovh_bit = ~nxt_frm[1];
            end
            if (insert_multiframe_en && !ft_frm && fmt == TOA_FMT_SF) begin
                ovh_bit = TOA_FS_PAT[k2];
            end
            if (insert_multiframe_en && nxt_frm[1:0] == 2'h3 && fmt == TOA_FMT_ESF) begin
                ovh_bit = TOA_FPS_PAT[k4];
            end
            if (jy_mode && yel_ins && nxt_frm == TOA_MF_LAST_SF) begin
                ovh_bit = 1'b1;
            end
        end else if (is_t1) begin
            if (yel_ins && yb2_mode && pos == TOA_BIT2_POS) begin
                ovh_bit = 1'b0;
            end
            if (yel_ins && fmt == TOA_FMT_T1DM && slot == TOA_SYNC_SLOT
                && pos == TOA_Y_POS) begin
                ovh_bit = 1'b0;
            end
        end else if (slot == 5'h00) begin
            if (ft_frm) begin
                if (insert_multiframe_en && pos != 3'h0) begin
                    ovh_bit = TOA_FAS_BYTE[3'h7 - pos];
                end
            end else begin
                if (insert_multiframe_en && pos == TOA_NFAS_POS) begin
                    ovh_bit = 1'b1;
                end
                if (insert_multiframe_en && pos == 3'h0 && nxt_frm < TOA_MFAS_FRAMES) begin
                    ovh_bit = TOA_MFAS_PAT[k2];
                end
                if (yel_ins && pos == TOA_A_POS) begin
                    ovh_bit = 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AIS selection and line output
    logic line_data_ff;
    logic line_stb_ff;
    wire  ais_force = man_ais | tx_clock_lost_ff;
    wire  ais_now   = ais_force | (ais_on_signal_loss_en & rx_signal_lost);
    wire  use_alt   = alt_ck_en & ais_force;
    wire  bit_stb   = use_alt ? alt_edge : tx_edge;
    // One line bit per selected clock edge; AIS replaces everything
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            line_data_ff <= 1'b1;
            line_stb_ff  <= 1'b0;
        end else begin
            line_stb_ff <= bit_stb;
            if (bit_stb) begin
                line_data_ff <= ais_now ? 1'b1 : ovh_bit;
            end
        end
    end
    // Outputs
    assign reg_rdata           = reg_rdata_ff;
    assign tx_line_data        = line_data_ff;
    assign tx_line_bit_stb     = line_stb_ff;
    assign tx_clock_lost       = tx_clock_lost_ff;
    assign ais_active          = ais_now;
    assign remote_alarm_active = yel_ins;
    assign line_loopback_en    = loop_ff[TOA_LOOP_LINE];
    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_ais_all_ones: assert property (
        bit_stb && ais_now |=> line_data_ff && line_stb_ff)
        else $error("AIS bit not all ones");
    chk_manual_ais: assert property (
        man_ais && bit_stb |=> tx_line_data) else $error("no manual AIS");
    chk_alt_timing: assert property (
        use_alt && alt_edge && !tx_edge |=> line_stb_ff)
        else $error("AIS not timed by alternate clock");
    chk_loss_set: assert property (
        alt_ck_en && !tx_edge && alt_edge && !tx_clock_lost_ff
        && loc_cnt_ff == 4'h7 |=> tx_clock_lost_ff ##0 ais_active)
        else $error("clock loss not flagged after eight edges");
    chk_loss_clear: assert property (
        tx_edge |=> !tx_clock_lost_ff) else $error("clock loss not cleared");
    chk_ais_on_signal_loss_en: assert property (
        ais_on_signal_loss_en && rx_signal_lost && bit_stb |=> tx_line_data)
        else $error("AIS missing on signal loss");
    chk_ft_bit: assert property (
        fbit && insert_frame_bit_en && ft_frm && fmt != TOA_FMT_ESF && !jy_mode
        |-> ovh_bit == ~nxt_frm[1]) else $error("Ft bit wrong");
    chk_bit2_zero: assert property (
        yel_ins && yb2_mode && is_t1 && !fbit && pos == TOA_BIT2_POS
        |-> !ovh_bit) else $error("bit 2 not forced low");
    chk_e1_abit: assert property (
        yel_ins && is_e1 && slot == 5'h00 && !ft_frm && pos == TOA_A_POS
        |-> ovh_bit) else $error("A bit not set");
    chk_yellow_gate: assert property (
        !insert_remote_alarm_en |-> !remote_alarm_active) else $error("yellow without enable");
    chk_lof_delay: assert property (
        integ_en && rx_frame_lost && !lof_ind_ff
        && lof_cnt_ff < TOA_TMR_W'(LOF_INTEG_CYC - 1) |=> !lof_ind_ff)
        else $error("loss indication not delayed");
    chk_yellow_hold: assert property (
        integ_en && remote_alarm_on_lof_en && insert_remote_alarm_en && $fell(lof_ind_ff)
        |-> remote_alarm_active [*8]) else $error("yellow hold too short");
    cov_manual_ais: cover property (man_ais && bit_stb);
    cov_clock_loss: cover property ($rose(tx_clock_lost_ff));
    cov_e1_yellow:  cover property (yel_ins && is_e1 && tx_edge);
    cov_lof_integ:  cover property (integ_en && $rose(lof_ind_ff));
endmodule : toa_tx_overhead
`default_nettype wire

// [test/toa_line_model.sv]
// Far-end line model: transmit and alternate clocks, system PCM source
`timescale 1ns/1ps
`default_nettype none

module toa_line_model (
    // Control
    input  wire logic run_tx,
    // Link pins
    output logic      tx_clock_in,
    output logic      alt_e1_clock_in,
    output logic      alt_t1_clock_in,
    output logic      system_pcm_in
);
    integer seed = 51865;

    ////////////////////////////////////////////////////////////////////////
    // Transmit clock parks low when stopped; PCM changes on falling edges and every half period while parked low
    initial begin
        tx_clock_in = 1'b0;
        system_pcm_in = 1'b0;
        forever begin
            #62.5;
            if (run_tx || tx_clock_in)
                tx_clock_in = ~tx_clock_in;
            if (!tx_clock_in)
                system_pcm_in = seed_bit();
        end
    end

    function automatic logic seed_bit();
        return 1'($random(seed));
    endfunction : seed_bit

    // Alternate clocks run free, out of phase with the transmit clock
    initial begin
        alt_e1_clock_in = 1'b0;
        alt_t1_clock_in = 1'b0;
        #20;
        forever begin
            #62.5;
            alt_e1_clock_in = ~alt_e1_clock_in;
            alt_t1_clock_in = ~alt_t1_clock_in;
        end
    end
endmodule : toa_line_model
`default_nettype wire

// [test/toa_tx_overhead_tb_top.sv]
// Self-checking testbench of the transmit overhead and alarm block
`timescale 1ns/1ps
`default_nettype none

module toa_tx_overhead_tb_top
    import toa_pkg::*;
;
    logic [9:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic       sys_clk, rst, reg_wr, reg_rd, run_tx, tx_frame_sync_in;
    logic       rx_signal_lost, rx_frame_lost, tx_line_data, tx_line_bit_stb;
    logic       tx_clock_in, alt_e1_clock_in, alt_t1_clock_in, system_pcm_in;
    logic       tx_clock_lost, ais_active, remote_alarm_active;
    logic       line_loopback_en;
    int         fails, compares, n;
    integer     seed = 51865;
    bit         q[$];

    toa_tx_overhead #(.LOF_INTEG_CYC(40), .YEL_HOLD_CYC(30)) i_toa_tx_overhead (
        .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .tx_clock_in, .alt_e1_clock_in, .alt_t1_clock_in, .system_pcm_in,
        .tx_frame_sync_in, .rx_signal_lost, .rx_frame_lost, .tx_line_data,
        .tx_line_bit_stb, .tx_clock_lost, .ais_active, .remote_alarm_active,
        .line_loopback_en);
    toa_line_model i_toa_line_model (.run_tx, .tx_clock_in,
        .alt_e1_clock_in, .alt_t1_clock_in, .system_pcm_in);

    ////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (90000) @(posedge sys_clk);
        fails++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////
    // Tasks: compare, register cycles, strobe wait, frame capture
    task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(logic [7:0] i, logic [7:0] v);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= {i, 2'h0};
        reg_wdata <= v;
        @(posedge sys_clk) reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(logic [7:0] i);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= {i, 2'h0};
        @(posedge sys_clk) reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic wstb();
        #8;
        for (n = 0; n < 40 && tx_line_bit_stb !== 1'b1; n++) #8;
    endtask : wstb
    task automatic cap(int len);
        @(negedge tx_clock_in);
        @(posedge sys_clk) tx_frame_sync_in <= 1'b1;
        q.delete();
        #1;
        while (q.size() < len) begin
            if (tx_line_bit_stb === 1'b1) q.push_back(tx_line_data);
            #8;
        end
        @(posedge sys_clk) tx_frame_sync_in <= 1'b0;
        #1;
    endtask : cap
    task automatic report_and_stop();
        $display("Compares %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst, run_tx} = 2'h3;
        {reg_wr, reg_rd, tx_frame_sync_in, rx_signal_lost} = 4'h0;
        {rx_frame_lost, reg_addr, reg_wdata} = 19'h0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rd(TOA_IDX_TX_FRAME_FORMAT);
        chk("format reset", d, TOA_REG_RST);
        rd(8'h00);
        chk("unmapped", d, 8'h00);
        d = 8'($random(seed));
        wr(TOA_IDX_LOOP, d);
        chk("loopback", line_loopback_en, d[0]);
        wr(TOA_IDX_TX_ALARM_CONFIG, 8'h01);
        wstb();
        repeat (8) begin
            wstb();
            chk("manual ais", tx_line_data, 8'h1);
        end
        wr(TOA_IDX_TX_ALARM_CONFIG, 8'h02);
        @(posedge sys_clk) rx_signal_lost <= 1'b1;
        #25 chk("ais on loss", ais_active, 8'h1);
        wstb();
        chk("loss ais line", tx_line_data, 8'h1);
        @(posedge sys_clk) rx_signal_lost <= 1'b0;
        #25 chk("ais off", ais_active, 8'h0);
        wr(TOA_IDX_TX_ALARM_CONFIG, 8'h00);
        wr(TOA_IDX_TLIU, 8'h01);
        @(posedge sys_clk) run_tx <= 1'b0;
        #401 chk("loss early", tx_clock_lost, 8'h0);
        for (n = 0; n < 400 && tx_clock_lost !== 1'b1; n++) #8;
        chk("clock lost", tx_clock_lost, 8'h1);
        chk("loss ais", ais_active, 8'h1);
        wstb();
        chk("alt ais", tx_line_data, 8'h1);
        @(posedge sys_clk) run_tx <= 1'b1;
        #1;
        for (n = 0; n < 400 && tx_clock_lost !== 1'b0; n++) #8;
        rd(TOA_IDX_TXST);
        chk("loss status", d[TOA_TXST_LOC], 8'h0);
        chk("clock back", ais_active, 8'h0);
        wr(TOA_IDX_TLIU, 8'h00);
        wr(TOA_IDX_TX_ALARM_CONFIG, 8'h04);
        wr(TOA_IDX_TX_FRAME_FORMAT, 8'h38);
        chk("manual yel", remote_alarm_active, 8'h1);
        cap(966);
        for (n = 0; n < 6; n++)
            chk("f bit", q[193*n], n[0] ? TOA_FS_PAT[n>>1] : !n[1]);
        chk("bit2 a", q[2], 8'h0);
        chk("bit2 b", q[10], 8'h0);
        wr(TOA_IDX_TX_FRAME_FORMAT, 8'h34);
        cap(259);
        for (n = 1; n < 8; n++)
            chk("fas", q[n], TOA_FAS_BYTE[7-n]);
        chk("nfas", q[257], 8'h1);
        chk("mfas", q[256], TOA_MFAS_PAT[0]);
        chk("a bit", q[258], 8'h1);
        wr(TOA_IDX_TX_FRAME_FORMAT, 8'h14);
        chk("no insert", remote_alarm_active, 8'h0);
        wr(TOA_IDX_TX_FRAME_FORMAT, 8'h34);
        wr(TOA_IDX_TX_ALARM_CONFIG, 8'h08);
        @(posedge sys_clk) rx_frame_lost <= 1'b1;
        #25 chk("remote_alarm_on_lof_en", remote_alarm_active, 8'h1);
        @(posedge sys_clk) rx_frame_lost <= 1'b0;
        #25 chk("remote_alarm_on_lof_en off", remote_alarm_active, 8'h0);
        wr(TOA_IDX_RECEIVE_ALARM_CONFIG, 8'h01);
        @(posedge sys_clk) rx_frame_lost <= 1'b1;
        #201 chk("integ early", remote_alarm_active, 8'h0);
        #240 chk("integ on", remote_alarm_active, 8'h1);
        rd(TOA_IDX_ALARM_STATUS_ONE);
        chk("lof status", d[TOA_ALARM_STATUS_ONE_LOF], 8'h1);
        @(posedge sys_clk) rx_frame_lost <= 1'b0;
        #161 chk("yel hold", remote_alarm_active, 8'h1);
        #200 chk("yel end", remote_alarm_active, 8'h0);
        wr(TOA_IDX_TX_ALARM_CONFIG, 8'h04);
        wr(TOA_IDX_TX_FRAME_FORMAT, 8'h23);
        cap(191);
        chk("t1dm y bit", q[190], 8'h0);
        wr(TOA_IDX_TX_FRAME_FORMAT, 8'h78);
        cap(2124);
        chk("japanese f12", q[2123], 8'h1);
        wr(TOA_IDX_TX_ALARM_CONFIG, 8'h00);
        wr(TOA_IDX_TX_FRAME_FORMAT, 8'h11);
        chk("esf no yel", remote_alarm_active, 8'h0);
        cap(580);
        chk("fps", q[579], TOA_FPS_PAT[0]);
        report_and_stop();
    end
endmodule : toa_tx_overhead_tb_top
`default_nettype wire
